// ### shared/sbldc_pkg.sv
package sbldc_pkg;
	// Clock and derived rates
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_HZ = 1_000_000;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int MON_MS = 1;
	localparam int MS_TICKS = MON_MS * TICK_HZ / 1000;
	localparam int PWM_HZ = 20_000;
	localparam int PWM_CYC = CLK_HZ / PWM_HZ;
	// Bus voltage scaling and limits
	localparam int ADC_FS_V = 111;
	localparam int ADC_MAX = 1023;
	localparam int OV_V = 28;
	localparam int UV_V = 15;
	localparam logic [9:0] OV_CODE = 10'(OV_V * ADC_MAX / ADC_FS_V);
	localparam logic [9:0] UV_CODE = 10'((UV_V * ADC_MAX + ADC_FS_V - 1) / ADC_FS_V);
	// Speed, timeout, start-up
	localparam int SPD_LIM_RPM = 3500;
	localparam int ZC_TO_MS = 50;
	localparam int POLE_PAIRS = 2;
	localparam int RPM_NUM = 60 * TICK_HZ / POLE_PAIRS;
	localparam int ALIGN_MS = 200;
	localparam int OL_STEP_MS = 20;
	localparam int OL_STEPS = 12;
	localparam int BOOT_VCMD = 48;
	localparam int VCMD_MAX = 1023;
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SPDCMD = 8'h04;
	localparam logic [7:0] REG_KP = 8'h08;
	localparam logic [7:0] REG_KI = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_SPEED = 8'h14;
	localparam logic [7:0] REG_VCMD = 8'h18;
	localparam logic [7:0] REG_DUTY = 8'h1c;
	// Field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_RESET_BIT = 2;
	localparam int CTRL_COMPL_BIT = 4;
	localparam int ST_SYS_LSB = 0;
	localparam int ST_RUN_LSB = 2;
	localparam int ST_HIZ_BIT = 4;
	localparam int ST_ERR_LSB = 8;
	// Error flag indices
	localparam int E_OC = 0;
	localparam int E_OV = 1;
	localparam int E_UV = 2;
	localparam int E_SPD = 3;
	localparam int E_ZC = 4;
	localparam int E_HALL = 5;
	localparam int N_ERR = 6;
	// Reset values
	localparam logic [15:0] SPDCMD_RST = 16'h03e8;
	localparam logic [15:0] KP_RST = 16'h0040;
	localparam logic [15:0] KI_RST = 16'h0004;
	localparam logic COMPL_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SBLDC_STOPPED, SBLDC_DRIVING, SBLDC_ERROR} sbldc_sys_t;
	typedef enum logic [1:0] {SBLDC_ALIGN, SBLDC_OPEN, SBLDC_SENSORLESS} sbldc_run_t;
	typedef enum logic [1:0] {SBLDC_C_IDLE, SBLDC_C_SPD, SBLDC_C_PI, SBLDC_C_DUTY} sbldc_seq_t;
endpackage

// ### hw/sbldc_supervisor.sv
// Summary of operation
// - Timer captured per commutation; speed over revolution
// - PI on speed error gives voltage command
// - Duty from voltage command over bus voltage
// - Chop first 60 degrees, complementary option
// - Three system states, moved only by events
// - Run sequence advances only while driving
// - Operator raises stop/run/reset; device raises error
// - Back-EMF position estimate every 60 degrees
// - Open-loop stepping pulls rotor to speed
// - Alignment phase at fixed boot voltage starts the run
// - Overcurrent trip puts pins high impedance
// - Bus above 28 V each 1 ms stops
// - Bus below 15 V each 1 ms stops
// - Speed above 3500 rpm each 1 ms stops
// - No zero-cross commutation in 50 ms stops
// - Invalid virtual Hall pattern stops
// - Protection trip disables all six gates
`timescale 1ns/100ps
`default_nettype none
module sbldc_supervisor #(
	parameter int PWM_PERIOD = sbldc_pkg::PWM_CYC,
	// Clocks per timer tick; a short value compresses every ms interval
	parameter int TICK_CYC = sbldc_pkg::TICK_DIV
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [9:0] vbus_code_i,
	input wire logic [2:0] virtual_hall_i,
	input wire logic overcurrent_trip_input_i,
	output logic [5:0] gate_o,
	output logic [5:0] gate_oe_o
);
	import sbldc_pkg::*;

	if (PWM_PERIOD < 2 || PWM_PERIOD > 65535) begin : g_chk
		$error("PWM_PERIOD must lie in 2..65535");
	end
	// Tick divider is eight bits wide
	if (TICK_CYC < 1 || TICK_CYC > 256) begin : g_tchk
		$error("TICK_CYC must lie in 1..256");
	end

	// Expected Hall pattern once the floating phase crosses
	function automatic logic [2:0] hall_exp(input logic [2:0] s);
		case (s)
			3'd0: hall_exp = 3'b101;
			3'd1: hall_exp = 3'b100;
			3'd2: hall_exp = 3'b110;
			3'd3: hall_exp = 3'b010;
			3'd4: hall_exp = 3'b011;
			default: hall_exp = 3'b001;
		endcase
	endfunction

	// High-side and low-side phase of each step
	function automatic logic [3:0] legs(input logic [2:0] s);
		case (s)
			3'd0: legs = {2'd0, 2'd1};
			3'd1: legs = {2'd0, 2'd2};
			3'd2: legs = {2'd1, 2'd2};
			3'd3: legs = {2'd1, 2'd0};
			3'd4: legs = {2'd2, 2'd0};
			default: legs = {2'd2, 2'd1};
		endcase
	endfunction

	// Byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
			input logic [3:0] st);
		merge16 = {st[1] ? d[15:8] : o[15:8], st[0] ? d[7:0] : o[7:0]};
	endfunction

	logic [7:0] tdiv; // Clock to 1 MHz divider
	logic tick; // 1 us enable
	logic [9:0] mdiv; // Tick to 1 ms divider
	logic ms_tick; // 1 ms enable
	logic [23:0] tmr; // Free-running timer
	logic oc_s1, oc_s2, oc_s3; // Overcurrent synchroniser
	logic [2:0] hall_s1, hall_s2; // Hall synchroniser
	logic aw_hold, w_hold; // Captured write halves
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic ev_run, ev_stop, ev_reset; // Operator events
	logic compl_mode; // Complementary chopping
	logic [15:0] spd_cmd, kp, ki;
	sbldc_sys_t sys_st;
	sbldc_run_t run_st;
	logic [N_ERR-1:0] trip, err_flags;
	logic hiz; // Pins released after overcurrent
	logic [2:0] step; // Conduction pattern 0..5
	logic [11:0] bcnt; // Boot phase ms counter
	logic [4:0] ol_n; // Open-loop steps taken
	logic zc_armed, dly_run, com_zc;
	logic [23:0] dly, last_com, step_per;
	logic [5:0] zc_ms; // Ms since last zero-cross switch
	logic [23:0] cap [6]; // Captures of one revolution
	logic [2:0] cptr, ncap;
	logic [23:0] rev_per;
	logic rev_ok;
	sbldc_seq_t seq;
	logic div_go;
	logic [31:0] div_num, div_den, quo;
	logic [31:0] rem;
	logic [5:0] div_cnt;
	logic [32:0] trial;
	logic [15:0] speed, vcmd, duty;
	logic signed [39:0] integ, next_integ, perr, pterm;
	logic signed [39:0] vsum;
	logic [15:0] next_vcmd;
	logic [15:0] pcnt;
	logic [5:0] next_gate;
	logic pwm_on;
	logic [31:0] rd_mux;

	// Rate dividers and free-running timer
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tdiv <= '0;
			tick <= 1'b0;
			mdiv <= '0;
			ms_tick <= 1'b0;
			tmr <= '0;
		end else begin
			tick <= (tdiv == 8'(TICK_CYC - 1));
			tdiv <= (tdiv == 8'(TICK_CYC - 1)) ? '0 : tdiv + 8'h01;
			ms_tick <= tick && (mdiv == 10'(MS_TICKS - 1));
			if (tick) begin
				mdiv <= (mdiv == 10'(MS_TICKS - 1)) ? '0 : mdiv + 10'h001;
				tmr <= tmr + 24'h000001;
			end
		end
	end

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			{oc_s1, oc_s2, oc_s3} <= 3'b111;
			hall_s1 <= 3'b001;
			hall_s2 <= 3'b001;
		end else begin
			oc_s1 <= overcurrent_trip_input_i;
			oc_s2 <= oc_s1;
			oc_s3 <= oc_s2;
			hall_s1 <= virtual_hall_i;
			hall_s2 <= hall_s1;
		end
	end

	// Protection checks; voltage and speed only on the 1 ms tick
	always_comb begin
		trip = '0;
		trip[E_OC] = oc_s3 && !oc_s2;
		if (sys_st == SBLDC_DRIVING && ms_tick) begin
			trip[E_OV] = (vbus_code_i > OV_CODE);
			trip[E_UV] = (vbus_code_i < UV_CODE);
		end
		if (sys_st == SBLDC_DRIVING && run_st == SBLDC_SENSORLESS) begin
			trip[E_SPD] = ms_tick && rev_ok && (speed > 16'(SPD_LIM_RPM));
			trip[E_ZC] = (zc_ms >= 6'(ZC_TO_MS));
			trip[E_HALL] = (hall_s2 == 3'b000) || (hall_s2 == 3'b111);
		end
	end

	// System state machine, moved by events only
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sys_st <= SBLDC_STOPPED;
		end else begin
			unique case (sys_st)
				SBLDC_STOPPED: begin
					if (|trip) sys_st <= SBLDC_ERROR;
					else if (ev_run) sys_st <= SBLDC_DRIVING;
				end
				SBLDC_DRIVING: begin
					if (|trip) sys_st <= SBLDC_ERROR;
					else if (ev_stop) sys_st <= SBLDC_STOPPED;
				end
				SBLDC_ERROR: begin
					// Reset ignored while a trip is still present
					if (ev_reset && !(|trip)) sys_st <= SBLDC_STOPPED;
				end
			endcase
		end
	end

	// Sticky error flags and pin release; a new trip beats the clear
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			err_flags <= '0;
			hiz <= 1'b0;
		end else begin
			err_flags <= (ev_reset ? '0 : err_flags) | trip;
			if (trip[E_OC]) hiz <= 1'b1;
			else if (ev_reset) hiz <= 1'b0;
		end
	end

	// Run sequence and commutation
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || sys_st != SBLDC_DRIVING) begin
			run_st <= SBLDC_ALIGN;
			step <= '0;
			bcnt <= '0;
			ol_n <= '0;
			zc_armed <= 1'b0;
			dly_run <= 1'b0;
			dly <= '0;
			com_zc <= 1'b0;
			last_com <= '0;
			step_per <= '0;
			zc_ms <= '0;
		end else begin
			com_zc <= 1'b0;
			unique case (run_st)
				SBLDC_ALIGN: begin
					// Hold step 0 at low voltage to park the rotor
					if (ms_tick) bcnt <= bcnt + 12'h001;
					if (bcnt == 12'(ALIGN_MS)) begin
						run_st <= SBLDC_OPEN;
						bcnt <= '0;
						last_com <= tmr;
					end
				end
				SBLDC_OPEN: begin
					// Forced steps regardless of rotor position
					if (ms_tick) bcnt <= bcnt + 12'h001;
					if (bcnt == 12'(OL_STEP_MS)) begin
						bcnt <= '0;
						step <= (step == 3'd5) ? 3'd0 : step + 3'd1;
						step_per <= tmr - last_com;
						last_com <= tmr;
						ol_n <= ol_n + 5'h01;
						if (ol_n == 5'(OL_STEPS - 1)) begin
							run_st <= SBLDC_SENSORLESS;
							zc_armed <= 1'b1;
						end
					end
				end
				SBLDC_SENSORLESS: begin
					if (ms_tick) zc_ms <= zc_ms + 6'h01;
					if (zc_armed && hall_s2 == hall_exp(step)) begin
						// Zero-cross seen; switch 30 degrees later
						zc_armed <= 1'b0;
						dly_run <= 1'b1;
						dly <= {1'b0, step_per[23:1]};
					end else if (dly_run && tick) begin
						if (dly == '0) begin
							dly_run <= 1'b0;
							zc_armed <= 1'b1;
							step <= (step == 3'd5) ? 3'd0 : step + 3'd1;
							step_per <= tmr - last_com;
							last_com <= tmr;
							com_zc <= 1'b1;
							zc_ms <= '0;
						end else begin
							dly <= dly - 24'h000001;
						end
					end
				end
				default: run_st <= SBLDC_ALIGN;
			endcase
		end
	end

	// Capture ring: period of one electrical revolution
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || run_st != SBLDC_SENSORLESS) begin
			cptr <= '0;
			ncap <= '0;
			rev_per <= '0;
			rev_ok <= 1'b0;
			for (int i = 0; i < 6; i++) cap[i] <= '0;
		end else if (com_zc) begin
			rev_per <= tmr - cap[cptr];
			rev_ok <= (ncap == 3'd6);
			cap[cptr] <= tmr;
			cptr <= (cptr == 3'd5) ? 3'd0 : cptr + 3'd1;
			if (ncap != 3'd6) ncap <= ncap + 3'd1;
		end
	end

	// Shared restoring divider, 32 cycles per quotient
	assign trial = {rem, quo[31]} - {1'b0, div_den};
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rem <= '0;
			quo <= '0;
			div_cnt <= '0;
		end else if (div_go) begin
			rem <= '0;
			quo <= div_num;
			div_cnt <= 6'd32;
		end else if (div_cnt != '0) begin
			rem <= trial[32] ? {rem[30:0], quo[31]} : trial[31:0];
			quo <= {quo[30:0], !trial[32]};
			div_cnt <= div_cnt - 6'd1;
		end
	end

	// PI arithmetic in Q8
	always_comb begin
		perr = 40'(signed'({1'b0, spd_cmd})) - 40'(signed'({1'b0, speed}));
		pterm = perr * 40'(signed'({1'b0, kp}));
		next_integ = integ + perr * 40'(signed'({1'b0, ki}));
		if (next_integ < 0) next_integ = '0;
		if (next_integ > 40'(VCMD_MAX * 256)) next_integ = 40'(VCMD_MAX * 256);
		vsum = (pterm >>> 8) + (next_integ >>> 8);
		if (vsum < 0) next_vcmd = '0;
		else if (vsum > 40'(VCMD_MAX)) next_vcmd = 16'(VCMD_MAX);
		else next_vcmd = vsum[15:0];
	end

	// Control sequence on each 1 ms tick
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || sys_st != SBLDC_DRIVING) begin
			seq <= SBLDC_C_IDLE;
			div_go <= 1'b0;
			div_num <= '0;
			div_den <= 32'h00000001;
			speed <= '0;
			vcmd <= '0;
			duty <= '0;
			integ <= 40'(BOOT_VCMD * 256); // Bumpless hand-over
		end else begin
			div_go <= 1'b0;
			unique case (seq)
				SBLDC_C_IDLE: begin
					if (ms_tick && run_st == SBLDC_SENSORLESS && rev_ok) begin
						div_num <= 32'(RPM_NUM);
						div_den <= {8'h00, rev_per};
						div_go <= 1'b1;
						seq <= SBLDC_C_SPD;
					end else if (ms_tick) begin
						seq <= SBLDC_C_PI;
					end
				end
				SBLDC_C_SPD: begin
					if (!div_go && div_cnt == '0) begin
						speed <= (quo > 32'h0000ffff) ? 16'hffff : quo[15:0];
						seq <= SBLDC_C_PI;
					end
				end
				SBLDC_C_PI: begin
					if (run_st == SBLDC_SENSORLESS && rev_ok) begin
						integ <= next_integ;
						vcmd <= next_vcmd;
						div_num <= 32'(next_vcmd) * 32'(PWM_PERIOD);
					end else begin
						vcmd <= 16'(BOOT_VCMD);
						div_num <= 32'(BOOT_VCMD) * 32'(PWM_PERIOD);
					end
					div_den <= {22'h0, vbus_code_i};
					div_go <= 1'b1;
					seq <= SBLDC_C_DUTY;
				end
				SBLDC_C_DUTY: begin
					if (!div_go && div_cnt == '0) begin
						// Never past the period
						duty <= (quo > 32'(PWM_PERIOD)) ? 16'(PWM_PERIOD) : quo[15:0];
						seq <= SBLDC_C_IDLE;
					end
				end
			endcase
		end
	end

	// PWM carrier
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) pcnt <= '0;
		else pcnt <= (pcnt == 16'(PWM_PERIOD - 1)) ? '0 : pcnt + 16'h0001;
	end
	assign pwm_on = (pcnt < duty);

	// Gate pattern: even steps chop high side, odd steps low side
	always_comb begin
		logic [3:0] lg;
		logic [1:0] hp, lp;
		lg = legs(step);
		hp = lg[3:2];
		lp = lg[1:0];
		next_gate = '0;
		if (!step[0]) begin
			next_gate[{hp, 1'b0}] = pwm_on;
			next_gate[{lp, 1'b1}] = 1'b1;
			if (compl_mode) next_gate[{hp, 1'b1}] = !pwm_on;
		end else begin
			next_gate[{hp, 1'b0}] = 1'b1;
			next_gate[{lp, 1'b1}] = pwm_on;
			if (compl_mode) next_gate[{lp, 1'b0}] = !pwm_on;
		end
	end

	// Output stage; off outside driving, released on overcurrent
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			gate_o <= '0;
			gate_oe_o <= '1;
		end else begin
			gate_oe_o <= (hiz || trip[E_OC]) ? '0 : '1;
			if (hiz || trip[E_OC] || |trip || sys_st != SBLDC_DRIVING) gate_o <= '0;
			else gate_o <= next_gate;
		end
	end

	// Register read mux
	always_comb begin
		rd_mux = '0;
		case (s_axi_araddr_i)
			REG_CTRL: rd_mux[CTRL_COMPL_BIT] = compl_mode;
			REG_SPDCMD: rd_mux[15:0] = spd_cmd;
			REG_KP: rd_mux[15:0] = kp;
			REG_KI: rd_mux[15:0] = ki;
			REG_STATUS: begin
				rd_mux[ST_SYS_LSB +: 2] = sys_st;
				rd_mux[ST_RUN_LSB +: 2] = run_st;
				rd_mux[ST_HIZ_BIT] = hiz;
				rd_mux[ST_ERR_LSB +: N_ERR] = err_flags;
			end
			REG_SPEED: rd_mux[15:0] = speed;
			REG_VCMD: rd_mux[15:0] = vcmd;
			REG_DUTY: rd_mux[15:0] = duty;
			default: rd_mux = '0;
		endcase
	end

	// AXI4-Lite write channel and writable registers
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			{aw_hold, w_hold} <= 2'b00;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			{ev_run, ev_stop, ev_reset} <= 3'b000;
			compl_mode <= COMPL_RST;
			spd_cmd <= SPDCMD_RST;
			kp <= KP_RST;
			ki <= KI_RST;
		end else begin
			{ev_run, ev_stop, ev_reset} <= 3'b000;
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr <= s_axi_awaddr_i;
				aw_hold <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				w_hold <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (aw_hold && w_hold && !s_axi_bvalid_o) begin
				{aw_hold, w_hold} <= 2'b00;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= RESP_OKAY;
				case (aw_addr)
					REG_CTRL: begin
						if (w_strb[0]) begin
							ev_run <= w_data[CTRL_RUN_BIT];
							ev_stop <= w_data[CTRL_STOP_BIT];
							ev_reset <= w_data[CTRL_RESET_BIT];
							compl_mode <= w_data[CTRL_COMPL_BIT];
						end
					end
					REG_SPDCMD: spd_cmd <= merge16(spd_cmd, w_data, w_strb);
					REG_KP: kp <= merge16(kp, w_data, w_strb);
					REG_KI: ki <= merge16(ki, w_data, w_strb);
					default: s_axi_bresp_o <= RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_mux;
			s_axi_rresp_o <= (s_axi_araddr_i[1:0] == 2'b00 && s_axi_araddr_i <= REG_DUTY) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verification/sbldc_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Port watcher for the supervisor
module sbldc_chk #(
	parameter int PWM_PERIOD = 100
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic overcurrent_trip_input_i,
	input wire logic [5:0] gate_o,
	input wire logic [5:0] gate_oe_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	logic [3:0] aw_age; // Cycles since a write address was taken
	// Saturating age, so only a recent write to any address may drive the pins again
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || (s_axi_awvalid_i && s_axi_awready_o)) begin
			aw_age <= 4'h0;
		end else if (aw_age != 4'hf) begin
			aw_age <= aw_age + 4'h1;
		end
	end
	a_no_shoot: assert property (!(|(gate_o & (gate_o >> 1) & 6'h15)))
		else $error("both switches of one leg on");
	a_one_upper: assert property ($countones({gate_o[4], gate_o[2], gate_o[0]}) <= 1)
		else $error("more than one upper switch on");
	a_oc_hiz: assert property ($fell(overcurrent_trip_input_i) |-> ##[1:5] (gate_oe_o == 6'h00))
		else $error("pins not released after trip");
	a_hiz_release: assert property ($rose(|gate_oe_o) |-> (aw_age <= 4'h6))
		else $error("pins driven again without a write");
	a_reset_vals: assert property ($fell(sys_rst_i) |-> (gate_o == 6'h00) && (&gate_oe_o))
		else $error("gate outputs wrong after reset");
	a_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
	a_write_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
endmodule
bind sbldc_supervisor sbldc_chk #(.PWM_PERIOD(PWM_PERIOD)) chk_u (.mclk_i, .sys_rst_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
	.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rvalid_o, .s_axi_rready_i, .overcurrent_trip_input_i, .gate_o, .gate_oe_o);
`default_nettype wire

// ### verification/sbldc_bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
// Inverter bridge and parked rotor on the gate side
module sbldc_bridge_model (
	input wire logic [5:0] gate_i,
	input wire logic [5:0] gate_oe_i,
	input wire logic [9:0] vbus_set_i,
	input wire logic trip_req_i,
	output logic [9:0] vbus_code_o,
	output logic [2:0] hall_o,
	output logic oc_n_o
);
	logic [5:0] drv; // Switches really conducting
	logic shoot; // Leg shorted across the bus
	assign drv = gate_i & gate_oe_i;
	// Unknown gates before reset must not fake a fault
	assign shoot = (|(drv & (drv >> 1) & 6'h15)) === 1'b1;
	// Bus divider reading follows the supply
	assign vbus_code_o = vbus_set_i;
	// Rotor held at the aligned position: a legal pattern
	assign hall_o = 3'b101;
	// Pulled-up fault line, falls on a commanded fault or a short
	assign oc_n_o = !(trip_req_i || shoot);
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the motor supervisor
module testbench;
	import sbldc_pkg::*;
	localparam int PER = 100; // Short PWM period keeps runs brief
	localparam int TMAX = 20000; // Cycle ceiling for the whole run
	localparam int MS_WAIT = 1100; // One 1 ms check plus the duty division
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, oc_n;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [9:0] vbus_code, vbus_set = 10'h0c8;
	logic [2:0] hall;
	logic trip_req = 1'b0;
	logic [5:0] gate, gate_oe;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 65068;
	int on_u, on_vl, stray, inv_ok; // Gate activity over one period
	int mdl [4]; // Model image of the writable registers
	// Free-running clock
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	// One tick per clock, so 1 ms is 1000 cycles and the checks fall inside the run
	sbldc_supervisor #(.PWM_PERIOD(PER), .TICK_CYC(1)) dut_u (.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .vbus_code_i(vbus_code),
		.virtual_hall_i(hall), .overcurrent_trip_input_i(oc_n), .gate_o(gate),
		.gate_oe_o(gate_oe));
	sbldc_bridge_model bridge_u (.gate_i(gate), .gate_oe_i(gate_oe), .vbus_set_i(vbus_set),
		.trip_req_i(trip_req), .vbus_code_o(vbus_code), .hall_o(hall), .oc_n_o(oc_n));
	// Comparison and mismatch report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == TMAX) begin
			n_mismatch++;
			stop_test();
		end
	end
	// Boot duty: boot voltage over bus code, never above the period
	function automatic int mduty(int v);
		return (BOOT_VCMD * PER / v > PER) ? PER : BOOT_VCMD * PER / v;
	endfunction
	// Bus write; response ready sometimes late to exercise the hold
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($random(seed));
		forever begin
			@(posedge mclk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			bready <= 1'b1;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// Bus read compared with the expectation
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'($random(seed));
		forever begin
			@(posedge mclk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			rready <= 1'b1;
		end
		rready <= 1'b0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// Watch one PWM period; m masks switches that must stay off
	task automatic watch(input logic [5:0] m);
		on_u = 0;
		on_vl = 0;
		stray = 0;
		inv_ok = 0;
		repeat (PER) begin
			@(negedge mclk_i);
			on_u += int'(gate[0] === 1'b1);
			on_vl += int'(gate[3] === 1'b1);
			stray += int'((gate & m) !== 6'h00);
			inv_ok += int'(gate[1] === ~gate[0]);
		end
		@(posedge mclk_i);
	endtask
	// Main sequence
	initial begin
		logic [31:0] d;
		mdl = '{0, int'(SPDCMD_RST), int'(KP_RST), int'(KI_RST)};
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) rdc(8'(4 * i), mdl[i], RESP_OKAY);
		rdc(REG_STATUS, 32'h0, RESP_OKAY);
		rdc(8'h20, 32'h0, RESP_SLVERR);
		rdc(8'h06, 32'h0, RESP_SLVERR);
		// Random gains and speed command, read back
		for (int i = 1; i < 4; i++) begin
			d = {16'h0, 16'($random(seed))};
			axw(8'(4 * i), d, RESP_OKAY);
			mdl[i] = d;
			rdc(8'(4 * i), mdl[i], RESP_OKAY);
		end
		axw(REG_STATUS, 32'h1, RESP_SLVERR);
		axw(8'h40, 32'h1, RESP_SLVERR);
		rdc(REG_STATUS, 32'h0, RESP_OKAY);
		// Run: boot alignment on step 0, upper U chopped, lower V on
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		repeat (4) @(posedge mclk_i);
		rdc(REG_STATUS, 32'h1, RESP_OKAY);
		// Duty is first loaded after the next 1 ms tick
		repeat (MS_WAIT) @(posedge mclk_i);
		rdc(REG_DUTY, mduty(200), RESP_OKAY);
		watch(6'h36);
		chk(on_u, mduty(200));
		chk(on_vl, PER);
		chk(stray, 0);
		// Complementary variant: lower U is the inverse of upper U
		axw(REG_CTRL, 32'h10, RESP_OKAY);
		rdc(REG_CTRL, 32'h10, RESP_OKAY);
		watch(6'h34);
		chk(inv_ok, PER);
		chk(on_u, mduty(200));
		// Low bus: undervoltage trip at the next 1 ms check, drive cleared
		vbus_set <= 10'h028;
		repeat (MS_WAIT) @(posedge mclk_i);
		rdc(REG_STATUS, 32'h402, RESP_OKAY);
		rdc(REG_DUTY, 32'h0, RESP_OKAY);
		watch(6'h3f);
		chk(on_u, 0);
		chk(stray, 0);
		vbus_set <= 10'h0c8;
		// Operator reset, run again, then a stop event halts the drive
		axw(REG_CTRL, 32'h14, RESP_OKAY);
		axw(REG_CTRL, 32'h11, RESP_OKAY);
		axw(REG_CTRL, 32'h12, RESP_OKAY);
		repeat (4) @(posedge mclk_i);
		rdc(REG_STATUS, 32'h0, RESP_OKAY);
		watch(6'h3f);
		chk(stray, 0);
		// Overcurrent while driving: pins released, error latched
		axw(REG_CTRL, 32'h11, RESP_OKAY);
		repeat (4) @(posedge mclk_i);
		trip_req <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk(gate_oe, 6'h00);
		chk(gate, 6'h00);
		rdc(REG_STATUS, 32'h112, RESP_OKAY);
		axw(REG_CTRL, 32'h11, RESP_OKAY);
		repeat (4) @(posedge mclk_i);
		rdc(REG_STATUS, 32'h112, RESP_OKAY);
		// Fault gone, operator reset returns to stopped
		trip_req <= 1'b0;
		repeat (8) @(posedge mclk_i);
		axw(REG_CTRL, 32'h14, RESP_OKAY);
		repeat (4) @(posedge mclk_i);
		rdc(REG_STATUS, 32'h0, RESP_OKAY);
		chk(gate_oe, 6'h3f);
		stop_test();
	end
endmodule
`default_nettype wire
